// *** dv/mcu_reset_sequencer_bench.sv ***
// Purpose: Self-checking bench for the reset sequencer.
// Assumes: Short wake and stretch counts; board model on pin.
// Notes:   Random register data, strobes and pulse lengths.
`timescale 1ns/100ps
`default_nettype none
module mcu_reset_sequencer_bench;
   import rst_seq_pkg::*;
   localparam int WAKE = 40;
   localparam int STRETCH = 60;
   localparam logic [95:0] RST_VALS = {{4{PORT_RST}}, SP_RST, {7{ZERO_RST}}};
   logic clk = 0, rst_n = 0, pin, oe, pout, wdt = 0, pd = 0, wake = 0, can_en = 0, gie = 0, ale = 0;
   logic prog_store = 0, we = 0, start = 0, clamp = 0, core_rst, can_rst, ale_o, prog_store_o, ram_ok;
   logic [3:0] idx = '0;
   logic [7:0] wdata = '0;
   logic [16:0] hold = '0;
   logic [95:0] vals, shadow;
   int error_cnt = 0, total_checks = 0, cycles = 0, seed = 32'hb160, n, c;
   mcu_reset_sequencer #(.WAKE_CYC(WAKE), .STRETCH_CYC(STRETCH)) mcu_reset_sequencer_inst (
      .CLK_SYS(clk), .RST_N(rst_n), .RST_PIN_IN(pin), .RST_PIN_OUT(pout), .RST_PIN_OE(oe),
      .WDT_OVERFLOW(wdt), .POWER_DOWN(pd), .CAN_WAKE(wake), .CAN_INT_EN(can_en), .GLOBAL_INT_EN(gie),
      .ALE_CORE(ale), .PROGRAM_STORE_CORE(prog_store), .ADDR_LATCH_STROBE(ale_o),
      .PROGRAM_STORE_STROBE(prog_store_o),
      .SFR_WE(we), .SFR_IDX(idx), .SFR_WDATA(wdata), .CORE_RESET(core_rst), .CAN_RESET(can_rst),
      .RAM_WRITE_ALLOW(ram_ok), .SFR_VALUES(vals));
   reset_board_model reset_board_model_inst (.clk(clk), .pull_out(pout), .pull_oe(oe), .start(start),
      .clamp_low(clamp),
      .hold_len(hold), .pin(pin));
   initial forever #2.5 clk = ~clk;
   // Hang guard, far above the roughly 1540 clocks needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic cyc(input int k); repeat (k) @(posedge clk); endtask : cyc
   task automatic board_go(input int len);
      @(posedge clk);
      {start, hold} <= {1'b1, 17'(len)};
      @(posedge clk);
      start <= 0;
   endtask : board_go
   // Random byte to every register, random strobes alongside
   task automatic write_rand();
      logic [7:0] d;
      for (int i = 0; i < NUM_SFR; i++) begin
         d = 8'($random(seed));
         shadow[i*8 +: 8] = d;
         @(posedge clk);
         {we, idx, wdata, ale, prog_store} <= {1'b1, 4'(i), d, d[1:0]};
      end
      @(posedge clk);
      we <= 0;
      cyc(1);
   endtask : write_rand
   // Clocks with pull-up and CAN reset high over a quiet window
   task automatic pulse_count(output int p, output int q);
      p = 0;
      q = 0;
      repeat (200) begin
         @(negedge clk);
         p += (oe === 1'b1);
         q += (can_rst === 1'b1);
      end
   endtask : pulse_count
   initial begin
      cyc(8);
      check("reset regs", RST_VALS, vals);
      check("reset strobes", 2'b11, {ale_o, prog_store_o});
      rst_n <= 1;
      cyc(2);
      @(negedge clk);
      check("run", 3'b001, {core_rst, can_rst, ram_ok});
      // Board pulses: one short of the limit, three random short, then exactly the limit
      for (int k = 0; k < 5; k++) begin
         write_rand();
         n = (k == 4) ? EXT_MIN_CYC : (k == 0) ? EXT_MIN_CYC - 1 : 1 + ($random(seed) & 15);
         board_go(n);
         // Pin is first sampled high one clock after the model loads, so the limit lands here
         cyc(EXT_MIN_CYC);
         @(negedge clk);
         check("pin reset", (k == 4) ? 3'b110 : 3'b001, {core_rst, can_rst, ram_ok});
         check("strobes", (k == 4) ? 2'b11 : shadow[89:88], {ale_o, prog_store_o});
         check("regs", (k == 4) ? RST_VALS : shadow, vals);
         cyc(8);
      end
      write_rand();
      // Board clamps the pin low: the watchdog reset must still run its full length
      @(posedge clk);
      {wdt, clamp} <= 2'b11;
      @(posedge clk);
      wdt <= 0;
      pulse_count(n, c);
      @(posedge clk);
      clamp <= 0;
      check("wdt pull-up", WDT_PULSE_CYC, n);
      check("wdt can reset", WDT_PULSE_CYC + 1, c);
      check("wdt regs", RST_VALS, vals);
      // Every enable mix, then power-down missing
      for (int k = 0; k < 5; k++) begin
         @(posedge clk);
         {pd, can_en, gie, wake} <= (k < 4) ? {1'b1, 2'(k), 1'b1} : 4'b0111;
         @(posedge clk);
         wake <= 0;
         pulse_count(n, c);
         check("wake pull-up", (k == 3) ? WAKE : 0, n);
         check("wake can reset", 0, c);
      end
      @(posedge clk);
      {pd, wake} <= 2'b11;
      board_go(STRETCH + 10);
      wake <= 0;
      cyc(STRETCH + 2);
      @(negedge clk);
      check("stretch", 3'b110, {core_rst, can_rst, ram_ok});
      summarize();
   end
endmodule : mcu_reset_sequencer_bench
`default_nettype wire

// *** dv/reset_board_model.sv ***
// Purpose: Board side of the reset pin.
// Assumes: Resistor to ground on the pin, no capacitor.
// Notes:   Board drive and device pull-up form a wired OR.
`timescale 1ns/100ps
`default_nettype none
module reset_board_model (
   // Clock, device pull-up, board request, pin
   input  wire logic        clk,
   input  wire logic        pull_out,
   input  wire logic        pull_oe,
   input  wire logic        start,
   input  wire logic        clamp_low,
   input  wire logic [16:0] hold_len,
   output var  logic        pin
);
   logic [16:0] left = '0;
   // High for hold_len clocks, then the resistor pulls low at once
   always @(posedge clk) left <= start ? hold_len : (left != 0) ? left - 1'b1 : left;
   // Strobe pins stay unloaded; pin is the wired OR unless the board clamps it low
   assign pin = !clamp_low && ((left != 0) || (pull_oe && pull_out));
endmodule : reset_board_model
`default_nettype wire

// *** dv/rst_seq_monitor.sv ***
// Purpose: Port checker for the reset sequencer.
// Assumes: One clock domain; bound to every sequencer.
// Notes:   Ages count clocks since each pulse began.
`timescale 1ns/100ps
`default_nettype none
module rst_seq_checker
   import rst_seq_pkg::*;
#(
   parameter int WAKE_CYC    = 40,
   parameter int STRETCH_CYC = 60
) (
   // Watched ports
   input wire logic CLK_SYS, RST_N, RST_PIN_IN, RST_PIN_OUT, RST_PIN_OE, WDT_OVERFLOW, POWER_DOWN,
   input wire logic CAN_WAKE, CAN_INT_EN, GLOBAL_INT_EN, ADDR_LATCH_STROBE, PROGRAM_STORE_STROBE,
   input wire logic CORE_RESET, CAN_RESET, RAM_WRITE_ALLOW,
   input wire logic [rst_seq_pkg::NUM_SFR*8-1:0] SFR_VALUES
);
   int   wdt_age;
   int   wake_age;
   int   pin_run;
   logic wake_ok;
   // A wake request is refused while a wake pulse still runs
   assign wake_ok = POWER_DOWN && CAN_WAKE && CAN_INT_EN && GLOBAL_INT_EN && !(wake_age inside {[1:WAKE_CYC]});
   // Pulse ages; pin run saturates so it never wraps
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wdt_age  <= 0;
         wake_age <= 0;
         pin_run  <= 0;
      end else begin
         wdt_age  <= WDT_OVERFLOW ? 1 : (wdt_age inside {[1:WDT_PULSE_CYC]}) ? wdt_age + 1 : 0;
         wake_age <= wake_ok ? 1 : (wake_age inside {[1:WAKE_CYC]}) ? wake_age + 1 : 0;
         pin_run  <= !(RST_PIN_IN || RST_PIN_OE) ? 0 : (pin_run > STRETCH_CYC) ? pin_run : pin_run + 1;
      end
   end
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   a_strobes_in_reset: assert property (CORE_RESET |-> ADDR_LATCH_STROBE && PROGRAM_STORE_STROBE)
      else $error("strobe low in reset");
   a_wdt_start: assert property (WDT_OVERFLOW |=> RST_PIN_OE && RST_PIN_OUT && CORE_RESET && CAN_RESET)
      else $error("no watchdog pulse");
   a_pulse_end_time: assert property ($fell(RST_PIN_OE) |->
      wdt_age == WDT_PULSE_CYC + 1 || wake_age == WAKE_CYC + 1) else $error("pull-up ended off time");
   a_wake_start: assert property (wake_ok && !CAN_RESET && !WDT_OVERFLOW |=>
      RST_PIN_OE && CORE_RESET && !CAN_RESET) else $error("wake pulse wrong");
   a_wake_gated: assert property (POWER_DOWN && CAN_WAKE && !(CAN_INT_EN && GLOBAL_INT_EN) &&
      !RST_PIN_OE && !WDT_OVERFLOW |=> !RST_PIN_OE) else $error("wake taken without enables");
   a_pin_qualify: assert property (pin_run >= EXT_MIN_CYC |-> CORE_RESET)
      else $error("long pin high not reset");
   a_sync_release: assert property ($fell(CORE_RESET) |-> !$past(RST_PIN_IN) && !$past(RST_PIN_OE))
      else $error("reset left early");
   a_regs_in_reset: assert property (CORE_RESET |-> !RAM_WRITE_ALLOW &&
      SFR_VALUES == {{4{PORT_RST}}, SP_RST, {7{ZERO_RST}}}) else $error("reset values wrong");
   c_wake: cover property (wake_ok);
   c_pulse_end: cover property ($fell(RST_PIN_OE));
   c_stretch: cover property (pin_run > STRETCH_CYC);
endmodule : rst_seq_checker
bind mcu_reset_sequencer rst_seq_checker #(.WAKE_CYC(WAKE_CYC), .STRETCH_CYC(STRETCH_CYC)) rst_seq_checker_inst (.*);
`default_nettype wire

// *** hw/mcu_reset_sequencer.sv ***
// Purpose: Reset sequencer: qualifies the reset pin, merges watchdog and wake-up pulses.
// Assumes: Inputs synchronous to CLK_SYS; CLK_SYS is the oscillator clock.
// Notes:   Drives the reset pin high through a pull-up; the pin level is read back on RST_PIN_IN.
//
// Functional notes
// - Address-latch and program-store strobes are driven high during reset.
// - Watchdog overflow pulls reset pin high for exactly three machine cycles.
// - CAN wake-up in power-down pulls reset pin high for 6144 machine cycles.
// - Wake-up reset leaves CAN controller and its registers untouched.
// - Internal pulses reset the device whatever level the pin shows.
// - Reset leaves main and auxiliary RAM contents unchanged.
// - Reset loads ACC, B, DPTR, PSW, PC zero, SP seven, ports all ones.
// - Pin held high beyond 8192 machine cycles also resets CAN controller.
// - Wake-up acts only if CAN interrupt source and global enable set.

`timescale 1ns/100ps
`default_nettype none

module mcu_reset_sequencer
   import rst_seq_pkg::*;
#(
   parameter int WAKE_CYC    = rst_seq_pkg::WAKE_PULSE_CYC,
   parameter int STRETCH_CYC = rst_seq_pkg::CAN_STRETCH_CYC
) (
   // Clock and reset
   input  wire logic                              CLK_SYS,
   input  wire logic                              RST_N,
   // Reset pin, open-drain style pull-up
   input  wire logic                              RST_PIN_IN,
   output var  logic                              RST_PIN_OUT,
   output var  logic                              RST_PIN_OE,
   // Reset sources and enables
   input  wire logic                              WDT_OVERFLOW,
   input  wire logic                              POWER_DOWN,
   input  wire logic                              CAN_WAKE,
   input  wire logic                              CAN_INT_EN,
   input  wire logic                              GLOBAL_INT_EN,
   // Bus strobes from the core, and to the pins
   input  wire logic                              ALE_CORE,
   input  wire logic                              PROGRAM_STORE_CORE,
   output var  logic                              ADDR_LATCH_STROBE,
   output var  logic                              PROGRAM_STORE_STROBE,
   // Core register write port
   input  wire logic                              SFR_WE,
   input  wire logic [rst_seq_pkg::SFR_IW-1:0]    SFR_IDX,
   input  wire logic [7:0]                        SFR_WDATA,
   // Reset outputs and register contents
   output var  logic                              CORE_RESET,
   output var  logic                              CAN_RESET,
   output var  logic                              RAM_WRITE_ALLOW,
   output var  logic [rst_seq_pkg::NUM_SFR*8-1:0] SFR_VALUES
);

   import rst_seq_pkg::*;

   // Counter widths follow the parameters and the watchdog pulse length
   localparam int PW = $clog2(STRETCH_CYC + 2);
   localparam int WW = $clog2(WAKE_CYC + 1);
   localparam int DW = $clog2(WDT_PULSE_CYC + 1);

   // Refuse settings the counters cannot serve
   if (WAKE_CYC < 1 || STRETCH_CYC < EXT_MIN_CYC) begin : g_bad_param
      $error("mcu_reset_sequencer: WAKE_CYC or STRETCH_CYC out of range");
   end

   // All state of the sequencer
   typedef struct packed {
      rst_state_t                  state;
      logic [PW-1:0]               pin_cnt;
      logic [DW-1:0]               wdt_cnt;
      logic [WW-1:0]               wake_cnt;
      logic                        pin_oe;
      logic                        core_rst;
      logic                        can_rst;
      logic                        ale;
      logic                        prog_store;
      logic                        ram_ok;
      logic [NUM_SFR-1:0][7:0]     sfr;
   } seq_state_t;

   // Reset value of one core register
   function automatic logic [7:0] sfr_reset_value(input int idx);
      logic [7:0] v;
      v = ZERO_RST;
      if (idx == IDX_SP) begin
         v = SP_RST;
      end
      if (idx >= IDX_P0 && idx <= IDX_P4) begin
         v = PORT_RST;
      end
      return v;
   endfunction : sfr_reset_value

   // Whole-state reset image; device comes up in full reset
   function automatic seq_state_t reset_image();
      seq_state_t r;
      r          = '0;
      r.state    = ST_FULL;
      r.core_rst = 1'b1;
      r.can_rst  = 1'b1;
      r.ale      = 1'b1;
      r.prog_store = 1'b1;
      r.ram_ok   = 1'b0;
      for (int i = 0; i < NUM_SFR; i++) begin
         r.sfr[i] = sfr_reset_value(i);
      end
      return r;
   endfunction : reset_image

   localparam seq_state_t RESET_STATE = reset_image();

   seq_state_t s;
   seq_state_t next_s;

   logic wake_start;
   logic pin_high;
   logic hold;
   logic ext_ok;
   logic stretched;

   // Next-state logic
   always_comb begin
      next_s = s;

      // Wake-up is honoured only from power-down with both enables set
      wake_start = POWER_DOWN & CAN_WAKE & CAN_INT_EN & GLOBAL_INT_EN
                   & (s.wake_cnt == '0);

      // Watchdog pulse: restart on every overflow
      if (WDT_OVERFLOW) begin
         next_s.wdt_cnt = DW'(WDT_PULSE_CYC);
      end else if (s.wdt_cnt != '0) begin
         next_s.wdt_cnt = s.wdt_cnt - 1'b1;
      end

      // Wake-up pulse
      if (wake_start) begin
         next_s.wake_cnt = WW'(WAKE_CYC);
      end else if (s.wake_cnt != '0) begin
         next_s.wake_cnt = s.wake_cnt - 1'b1;
      end

      // Pull-up active while either pulse counter runs
      next_s.pin_oe = (next_s.wdt_cnt != '0) | (next_s.wake_cnt != '0);

      // Pin level as seen: our own pull-up counts even if the board holds it low
      pin_high = RST_PIN_IN | s.pin_oe;
      if (!pin_high) begin
         next_s.pin_cnt = '0;
      end else if (s.pin_cnt <= PW'(STRETCH_CYC)) begin
         next_s.pin_cnt = s.pin_cnt + 1'b1;                           // Saturates just past the limit
      end

      // Pin qualified after the minimum high time
      ext_ok    = next_s.pin_cnt >= PW'(EXT_MIN_CYC);
      stretched = next_s.pin_cnt > PW'(STRETCH_CYC);

      // Hold reset while pin qualified or a pulse runs
      hold = ext_ok | next_s.pin_oe;

      // Sequencer: wake-only reset spares the CAN controller
      case (s.state)
         ST_RUN: begin
            if (hold) begin
               if (next_s.wake_cnt != '0 && next_s.wdt_cnt == '0 && !ext_ok) begin
                  next_s.state = ST_KEEP_CAN;
               end else begin
                  next_s.state = ST_FULL;
               end
            end
         end
         ST_KEEP_CAN: begin
            if (!hold) begin
               next_s.state = ST_RUN;
            end else if (stretched || WDT_OVERFLOW) begin
               next_s.state = ST_FULL;
            end
         end
         ST_FULL: begin
            if (!hold) begin
               next_s.state = ST_RUN;
            end
         end
         default: begin
            next_s.state = ST_FULL;
         end
      endcase

      next_s.core_rst = (next_s.state != ST_RUN);
      next_s.can_rst  = (next_s.state == ST_FULL);

      // Strobes forced high while in reset; board must leave them alone
      next_s.ale  = next_s.core_rst | ALE_CORE;
      next_s.prog_store = next_s.core_rst | PROGRAM_STORE_CORE;

      // RAM writes blocked in reset so its contents survive
      next_s.ram_ok = ~next_s.core_rst;

      // Core registers: reset values in reset, else core writes
      for (int i = 0; i < NUM_SFR; i++) begin
         if (next_s.core_rst) begin
            next_s.sfr[i] = sfr_reset_value(i);
         end else if (SFR_WE && SFR_IDX == SFR_IW'(i)) begin
            next_s.sfr[i] = SFR_WDATA;
         end
      end
   end

   // State register
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from flip-flops
   assign RST_PIN_OUT          = s.pin_oe;
   assign RST_PIN_OE           = s.pin_oe;
   assign ADDR_LATCH_STROBE    = s.ale;
   assign PROGRAM_STORE_STROBE = s.prog_store;
   assign CORE_RESET           = s.core_rst;
   assign CAN_RESET            = s.can_rst;
   assign RAM_WRITE_ALLOW      = s.ram_ok;
   assign SFR_VALUES           = s.sfr;

endmodule : mcu_reset_sequencer

`default_nettype wire

// *** hw/rst_seq_pkg.sv ***
// Purpose: Shared constants and types for the microcontroller reset sequencer.
// Assumes: The system clock is the oscillator clock; one machine cycle is twelve oscillator periods.
// Notes:   Times are given in machine cycles; cycle counts are derived from them.

package rst_seq_pkg;

   // Oscillator periods in one machine cycle
   localparam int OSC_PER_MC     = 12;

   // Times in machine cycles
   localparam int EXT_MIN_MC     = 2;
   localparam int WDT_PULSE_MC   = 3;
   localparam int WAKE_PULSE_MC  = 6144;
   localparam int CAN_STRETCH_MC = 8192;

   // Same times in oscillator clock cycles
   localparam int EXT_MIN_CYC     = EXT_MIN_MC * OSC_PER_MC;
   localparam int WDT_PULSE_CYC   = WDT_PULSE_MC * OSC_PER_MC;
   localparam int WAKE_PULSE_CYC  = WAKE_PULSE_MC * OSC_PER_MC;
   localparam int CAN_STRETCH_CYC = CAN_STRETCH_MC * OSC_PER_MC;

   // Core registers that reset loads, by index
   localparam int NUM_SFR  = 12;
   localparam int SFR_IW   = 4;
   localparam int IDX_ACC  = 0;
   localparam int IDX_B    = 1;
   localparam int IDX_DPL  = 2;
   localparam int IDX_DPH  = 3;
   localparam int IDX_PSW  = 4;
   localparam int IDX_PCL  = 5;
   localparam int IDX_PCH  = 6;
   localparam int IDX_SP   = 7;
   localparam int IDX_P0   = 8;
   localparam int IDX_P4   = 11;

   // Reset values
   localparam logic [7:0] ZERO_RST = 8'h00;
   localparam logic [7:0] SP_RST   = 8'h07;
   localparam logic [7:0] PORT_RST = 8'hff;

   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_RUN      = 3'b001,
      ST_FULL     = 3'b010,
      ST_KEEP_CAN = 3'b100
   } rst_state_t;

endpackage : rst_seq_pkg
